/* File: core/pmf_pkg.sv */
// constants, layouts and state encodings of the management/fault block
package pmf_pkg;
   localparam int PMF_CLK_MHZ = 200;
   localparam int PMF_MDC_MAX_MHZ = 8;
   localparam int PMF_NLP_PERIOD_US = 16;
   localparam int PMF_NLP_CYCLES = PMF_NLP_PERIOD_US * PMF_CLK_MHZ;
   localparam int PMF_FAR_END_FAULT_PATTERN_ONES = 84;
   localparam logic [1:0] PMF_FAR_END_FAULT_PATTERN_MIN_UNITS = 2'h3;
   localparam logic [5:0] PMF_PREAMBLE_ONES = 6'h20;
   localparam logic [1:0] PMF_STRAP_SETTLE = 2'h3;
   localparam logic [1:0] PMF_OP_WRITE = 2'h1;
   localparam logic [1:0] PMF_OP_READ = 2'h2;
   // register indices; byte address on the bus is four times the index
   localparam logic [4:0] PMF_IDX_CTRL = 5'h00;
   localparam logic [4:0] PMF_IDX_STAT = 5'h01;
   localparam logic [4:0] PMF_IDX_ADV = 5'h04;
   localparam logic [4:0] PMF_IDX_LPA = 5'h05;
   localparam logic [4:0] PMF_IDX_CFG = 5'h10;
   localparam logic [4:0] PMF_IDX_IEN = 5'h12;
   localparam logic [4:0] PMF_IDX_IST = 5'h13;
   localparam logic [4:0] PMF_IDX_DRV = 5'h1A;
   // field positions
   localparam int PMF_CTRL_RESET = 15;
   localparam int PMF_CTRL_LOOP = 14;
   localparam int PMF_CTRL_SPEED = 13;
   localparam int PMF_CTRL_ANEN = 12;
   localparam int PMF_CTRL_RESTART = 9;
   localparam int PMF_CTRL_FDX = 8;
   localparam int PMF_STAT_ANDONE = 5;
   localparam int PMF_STAT_RFAULT = 4;
   localparam int PMF_STAT_LINK = 2;
   localparam int PMF_ABL_RFAULT = 13;
   localparam int PMF_ABL_100FD = 8;
   localparam int PMF_ABL_100HD = 7;
   localparam int PMF_ABL_10FD = 6;
   localparam int PMF_ABL_10HD = 5;
   localparam int PMF_CFG_FIBER = 0;
   localparam int PMF_CFG_FAR_END_FAULT_PATTERN_EN = 2;
   localparam int PMF_IEN_EN = 1;
   localparam int PMF_IEV_LSB = 4;
   localparam int PMF_IST_PEND = 2;
   localparam int PMF_DRV_HIGH = 11;
   // reset values
   localparam logic [15:0] PMF_CTRL_RST = 16'h3100;
   localparam logic [15:0] PMF_STAT_ABIL = 16'h7809;
   localparam logic [15:0] PMF_ADV_RST = 16'h01E1;
   localparam logic [15:0] PMF_CFG_RST = 16'h0000;
   localparam logic [15:0] PMF_IEN_RST = 16'h0000;
   localparam logic [15:0] PMF_DRV_RST = 16'h0000;
   // gray along idle -> header -> turnaround -> data
   typedef enum logic [1:0] {
      PMF_MS_PRE = 2'b00,
      PMF_MS_HDR = 2'b01,
      PMF_MS_TA = 2'b11,
      PMF_MS_DAT = 2'b10
   } pmf_mstate_t;
endpackage : pmf_pkg

/* File: core/pmf_top.sv */
// management port, strap configuration, link resolution and fault logic
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pmf_top
   import pmf_pkg::*;
#(
   parameter int unsigned NLP_CYCLES = PMF_NLP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr_pin,
   input wire logic mgmt_port_disable,
   input wire logic [2:0] led_strap_pin_i,
   output logic [2:0] led_strap_pin_o,
   output logic led_strap_pin_oe,
   input wire logic fiber_signal_detect,
   input wire logic rx_pll_lock,
   input wire logic link_ok,
   input wire logic tx_active,
   input wire logic an_done,
   input wire logic partner_page_valid,
   input wire logic [15:0] partner_page,
   input wire logic pd_link_pulse,
   input wire logic pd_idle_symbols,
   output logic [15:0] adv_page,
   output logic speed_100,
   output logic full_duplex,
   output logic link_up,
   output logic rx_block,
   output logic link_pulse,
   output logic far_end_fault_pattern,
   output logic far_end_fault_pattern_active,
   output logic mii_high_drive,
   output logic mgmt_irq_n_o,
   output logic mgmt_irq_oe
);

   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      logic [2:0] mdc_sy;
      logic [1:0] mdio_sy;
      logic [1:0] sd_sy;
      logic [1:0] dis_sy;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic [4:0] addr_s1;
      logic [4:0] addr_s2;
      logic [1:0] init_cnt;
      logic init_done;
      pmf_mstate_t mst;
      logic [5:0] ones;
      logic [4:0] cnt;
      logic [12:0] hdr;
      logic [15:0] sh;
      logic rd_op;
      logic wr_ok;
      logic mdio_o;
      logic mdio_oe;
      logic [15:0] r0;
      logic [15:0] r4;
      logic [15:0] r5;
      logic [15:0] r16;
      logic [15:0] r18;
      logic [15:0] r26;
      logic rfault;
      logic [3:0] ist;
      logic spd;
      logic fdx;
      logic an_p;
      logic spd_p;
      logic fdx_p;
      logic link_p;
      logic [21:0] nlp_cnt;
      logic nlp;
      logic far_end_fault_pattern_act;
      logic [6:0] far_end_fault_pattern_bit;
      logic [1:0] far_end_fault_pattern_units;
      logic far_end_fault_pattern_o;
      logic [31:0] prdata;
      logic [2:0] led;
      logic led_oe;
   } pmf_state_t;

   pmf_state_t s_q, s_d;
   logic fiber, sd_ok, link_now, mdc_rise, mdio_bit;

   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic logic [15:0] rd_reg(input logic [4:0] idx);
      logic [15:0] v;
      v = 16'h0000;
      case (idx)
         PMF_IDX_CTRL: v = s_q.r0;
         PMF_IDX_STAT: begin
            v = PMF_STAT_ABIL;
            v[PMF_STAT_ANDONE] = an_done;
            v[PMF_STAT_RFAULT] = s_q.rfault;
            v[PMF_STAT_LINK] = link_now;
         end
         PMF_IDX_ADV: v = s_q.r4;
         PMF_IDX_LPA: v = s_q.r5;
         PMF_IDX_CFG: v = s_q.r16;
         PMF_IDX_IEN: v = s_q.r18;
         PMF_IDX_IST: begin
            v[PMF_IEV_LSB +: 4] = s_q.ist;
            v[PMF_IST_PEND] = |(s_q.ist & s_q.r18[PMF_IEV_LSB +: 4]);
         end
         PMF_IDX_DRV: v = s_q.r26;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : rd_reg

   // ***********************************************************
   // combinational status
   // ***********************************************************
   assign fiber = s_q.r16[PMF_CFG_FIBER];
   assign sd_ok = s_q.sd_sy[1];
   assign link_now = link_ok & ~(fiber & ~sd_ok);
   assign mdc_rise = s_q.mdc_sy[1] & ~s_q.mdc_sy[2];
   assign mdio_bit = s_q.mdio_sy[1];

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb begin
      logic [1:0] wen;
      logic [4:0] widx [2];
      logic [15:0] wdat [2];
      logic clr19, clr1, hdr_ok, match;
      logic [15:0] best;
      logic [3:0] ev;
      s_d = s_q;
      wen = 2'b00;
      widx[0] = 5'h00;
      widx[1] = 5'h00;
      wdat[0] = 16'h0000;
      wdat[1] = 16'h0000;
      clr19 = 1'b0;
      clr1 = 1'b0;
      hdr_ok = 1'b0;
      match = 1'b0;
      best = 16'h0000;
      ev = 4'h0;

      // two-flop synchronisers; the first stage feeds only the second
      s_d.mdc_sy = {s_q.mdc_sy[1:0], mdc};
      s_d.mdio_sy = {s_q.mdio_sy[0], mdio_i};
      s_d.sd_sy = {s_q.sd_sy[0], fiber_signal_detect};
      s_d.dis_sy = {s_q.dis_sy[0], mgmt_port_disable};
      s_d.strap_s1 = led_strap_pin_i;
      s_d.strap_s2 = s_q.strap_s1;
      s_d.addr_s1 = phy_addr_pin;
      s_d.addr_s2 = s_q.addr_s1;

      // straps read once the synchronisers have settled after reset
      if (!s_q.init_done) begin
         if (s_q.init_cnt == PMF_STRAP_SETTLE) begin
            s_d.init_done = 1'b1;
            s_d.r0[PMF_CTRL_ANEN] = s_q.strap_s2[0];
            s_d.r0[PMF_CTRL_SPEED] = s_q.strap_s2[1];
            s_d.r0[PMF_CTRL_FDX] = s_q.strap_s2[2];
            s_d.r16[PMF_CFG_FIBER] = sd_ok;
         end else begin
            s_d.init_cnt = s_q.init_cnt + 2'h1;
         end
      end

      // management frame receiver, sampled on mdc rising edges
      if (mdc_rise) begin
         case (s_q.mst)
            PMF_MS_PRE: begin
               if (mdio_bit) begin
                  if (s_q.ones != PMF_PREAMBLE_ONES)
                     s_d.ones = s_q.ones + 6'h01;
               end else if (s_q.ones == PMF_PREAMBLE_ONES) begin
                  s_d.mst = PMF_MS_HDR;
                  s_d.cnt = 5'h00;
               end else begin
                  s_d.ones = 6'h00;
               end
            end
            PMF_MS_HDR: begin
               s_d.hdr = {s_q.hdr[11:0], mdio_bit};
               s_d.cnt = s_q.cnt + 5'h01;
               if (s_q.cnt == 5'h0C) begin
                  hdr_ok = s_d.hdr[12] & ((s_d.hdr[11:10] == PMF_OP_READ)
                     | (s_d.hdr[11:10] == PMF_OP_WRITE));
                  match = (s_d.hdr[9:5] == s_q.addr_s2) & ~s_q.dis_sy[1];
                  s_d.rd_op = s_d.hdr[11:10] == PMF_OP_READ;
                  s_d.wr_ok = match;
                  s_d.cnt = 5'h00;
                  s_d.ones = 6'h00;
                  s_d.mst = hdr_ok ? PMF_MS_TA : PMF_MS_PRE;
                  if (hdr_ok && match && s_d.rd_op) begin
                     s_d.sh = rd_reg(s_d.hdr[4:0]);
                     clr19 = s_d.hdr[4:0] == PMF_IDX_IST;
                     clr1 = s_d.hdr[4:0] == PMF_IDX_STAT;
                  end
               end
            end
            PMF_MS_TA: begin
               s_d.cnt = s_q.cnt + 5'h01;
               if (s_q.cnt == 5'h00) begin
                  s_d.mdio_oe = s_q.rd_op & s_q.wr_ok;
                  s_d.mdio_o = 1'b0;
               end else begin
                  s_d.mst = PMF_MS_DAT;
                  s_d.cnt = 5'h00;
                  s_d.mdio_o = s_q.sh[15];
               end
            end
            default: begin
               s_d.cnt = s_q.cnt + 5'h01;
               if (s_q.rd_op) begin
                  s_d.sh = {s_q.sh[14:0], 1'b0};
                  s_d.mdio_o = s_q.sh[14];
               end else begin
                  s_d.sh = {s_q.sh[14:0], mdio_bit};
               end
               if (s_q.cnt == 5'h0F) begin
                  s_d.mst = PMF_MS_PRE;
                  s_d.mdio_oe = 1'b0;
                  s_d.mdio_o = 1'b0;
                  if (!s_q.rd_op && s_q.wr_ok && !s_q.dis_sy[1]) begin
                     wen[0] = 1'b1;
                     widx[0] = s_q.hdr[4:0];
                     wdat[0] = {s_q.sh[14:0], mdio_bit};
                  end
               end
            end
         endcase
      end
      if (s_q.dis_sy[1])
         s_d.mdio_oe = 1'b0;

      // bus slave: zero wait, data captured in the setup cycle
      if (psel && !penable)
         s_d.prdata = {16'h0000, paddr[7] ? 16'h0000 : rd_reg(paddr[6:2])};
      if (psel && penable && !paddr[7]) begin
         if (pwrite) begin
            wen[1] = 1'b1;
            widx[1] = paddr[6:2];
            wdat[1] = pwdata[15:0];
         end else begin
            clr19 = clr19 | (paddr[6:2] == PMF_IDX_IST);
            clr1 = clr1 | (paddr[6:2] == PMF_IDX_STAT);
         end
      end

      // register writes; self-clearing command bits drop first
      s_d.r0[PMF_CTRL_RESET] = 1'b0;
      s_d.r0[PMF_CTRL_RESTART] = 1'b0;
      for (int k = 0; k < 2; k++) begin
         if (wen[k]) begin
            case (widx[k])
               PMF_IDX_CTRL: s_d.r0 = wdat[k];
               PMF_IDX_ADV: s_d.r4 = wdat[k];
               PMF_IDX_CFG: s_d.r16 = wdat[k];
               PMF_IDX_IEN: s_d.r18 = wdat[k];
               PMF_IDX_DRV: s_d.r26 = wdat[k];
               default: ;
            endcase
         end
      end

      // partner page capture; fault only on copper negotiation
      if (partner_page_valid && s_q.r0[PMF_CTRL_ANEN]) begin
         s_d.r5 = partner_page;
         if (fiber)
            s_d.r5[PMF_ABL_RFAULT] = 1'b0;
      end
      s_d.rfault = (s_q.rfault & ~clr1) | (partner_page_valid
         & s_q.r0[PMF_CTRL_ANEN] & ~fiber & partner_page[PMF_ABL_RFAULT]);

      // speed and duplex resolution
      best = s_q.r4 & s_q.r5;
      if (fiber) begin
         s_d.spd = 1'b1;
         s_d.fdx = s_q.r0[PMF_CTRL_FDX];
      end else if (!s_q.r0[PMF_CTRL_ANEN]) begin
         s_d.spd = s_q.r0[PMF_CTRL_SPEED];
         s_d.fdx = s_q.r0[PMF_CTRL_FDX];
      end else if (an_done) begin
         s_d.spd = best[PMF_ABL_100FD] | best[PMF_ABL_100HD];
         s_d.fdx = best[PMF_ABL_100FD] | (~best[PMF_ABL_100HD]
            & best[PMF_ABL_10FD]);
      end else if (pd_idle_symbols) begin
         s_d.spd = 1'b1;
         s_d.fdx = 1'b0;
      end else if (pd_link_pulse) begin
         s_d.spd = 1'b0;
         s_d.fdx = 1'b0;
      end

      // interrupt events; a new event beats a same-cycle clear
      s_d.an_p = an_done;
      s_d.spd_p = s_q.spd;
      s_d.fdx_p = s_q.fdx;
      s_d.link_p = link_now;
      ev = {an_done & ~s_q.an_p, s_q.spd ^ s_q.spd_p,
         s_q.fdx ^ s_q.fdx_p, link_now ^ s_q.link_p};
      s_d.ist = (s_q.ist & ~{4{clr19}}) | ev;

      // copper 10 Mbps idle keep-alive pulses
      s_d.nlp = 1'b0;
      if (fiber || s_q.spd || tx_active) begin
         s_d.nlp_cnt = 22'h000000;
      end else if (s_q.nlp_cnt == 22'(NLP_CYCLES - 1)) begin
         s_d.nlp_cnt = 22'h000000;
         s_d.nlp = 1'b1;
      end else begin
         s_d.nlp_cnt = s_q.nlp_cnt + 22'h000001;
      end

      // far-end fault units, at least the minimum count once begun
      if (!s_q.far_end_fault_pattern_act) begin
         if (fiber && s_q.r16[PMF_CFG_FAR_END_FAULT_PATTERN_EN] && (!sd_ok || !rx_pll_lock)
               && !s_q.r0[PMF_CTRL_LOOP]) begin
            s_d.far_end_fault_pattern_act = 1'b1;
            s_d.far_end_fault_pattern_bit = 7'h00;
            s_d.far_end_fault_pattern_units = 2'h0;
            s_d.far_end_fault_pattern_o = 1'b1;
         end
      end else if (s_q.far_end_fault_pattern_bit == 7'(PMF_FAR_END_FAULT_PATTERN_ONES)) begin
         s_d.far_end_fault_pattern_bit = 7'h00;
         if (s_q.far_end_fault_pattern_units != PMF_FAR_END_FAULT_PATTERN_MIN_UNITS)
            s_d.far_end_fault_pattern_units = s_q.far_end_fault_pattern_units + 2'h1;
         if (s_d.far_end_fault_pattern_units == PMF_FAR_END_FAULT_PATTERN_MIN_UNITS && !(fiber
               && s_q.r16[PMF_CFG_FAR_END_FAULT_PATTERN_EN] && (!sd_ok || !rx_pll_lock)
               && !s_q.r0[PMF_CTRL_LOOP])) begin
            s_d.far_end_fault_pattern_act = 1'b0;
            s_d.far_end_fault_pattern_o = 1'b0;
         end else begin
            s_d.far_end_fault_pattern_o = 1'b1;
         end
      end else begin
         s_d.far_end_fault_pattern_bit = s_q.far_end_fault_pattern_bit + 7'h01;
         s_d.far_end_fault_pattern_o = s_d.far_end_fault_pattern_bit != 7'(PMF_FAR_END_FAULT_PATTERN_ONES);
      end

      // strap pins turn into status lamps once sampled
      s_d.led_oe = s_q.init_done;
      s_d.led = {link_now, s_q.spd, s_q.fdx};
   end

   // ***********************************************************
   // registers
   // ***********************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.mst <= PMF_MS_PRE;
         s_q.r0 <= PMF_CTRL_RST;
         s_q.r4 <= PMF_ADV_RST;
         s_q.r16 <= PMF_CFG_RST;
         s_q.r18 <= PMF_IEN_RST;
         s_q.r26 <= PMF_DRV_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign prdata = s_q.prdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & paddr[7];
   assign mdio_o = s_q.mdio_o;
   assign mdio_oe = s_q.mdio_oe;
   assign led_strap_pin_o = s_q.led;
   assign led_strap_pin_oe = s_q.led_oe;
   // fault bit withheld from fiber pages
   assign adv_page = fiber ? (s_q.r4 & ~(16'h0001 << PMF_ABL_RFAULT))
      : s_q.r4;
   assign speed_100 = s_q.spd;
   assign full_duplex = s_q.fdx;
   assign link_up = link_now;
   assign rx_block = fiber & ~sd_ok;
   assign link_pulse = s_q.nlp;
   assign far_end_fault_pattern = s_q.far_end_fault_pattern_o;
   assign far_end_fault_pattern_active = s_q.far_end_fault_pattern_act;
   assign mii_high_drive = s_q.r26[PMF_DRV_HIGH];
   assign mgmt_irq_oe = s_q.r18[PMF_IEN_EN];
   assign mgmt_irq_n_o = ~|(s_q.ist & s_q.r18[PMF_IEV_LSB +: 4]);

   // ***********************************************************
   // checks
   // ***********************************************************
   property p_irq_drive;
      @(posedge ref_clk) disable iff (!rst_n)
      !s_q.r18[PMF_IEN_EN] |-> !mgmt_irq_oe;
   endproperty
   a_irq_drive: assert property (p_irq_drive) else $error("irq driven while off");

   property p_irq_low;
      @(posedge ref_clk) disable iff (!rst_n)
      (mgmt_irq_oe && |(s_q.ist & s_q.r18[PMF_IEV_LSB +: 4]))
         |-> !mgmt_irq_n_o;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("pending irq not low");

   property p_link_event;
      @(posedge ref_clk) disable iff (!rst_n)
      (link_now != s_q.link_p) |=> s_q.ist[0];
   endproperty
   a_link_event: assert property (p_link_event) else $error("link event lost");

   property p_far_end_fault_pattern_ones;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(far_end_fault_pattern_active) |-> far_end_fault_pattern [*8];
   endproperty
   a_far_end_fault_pattern_ones: assert property (p_far_end_fault_pattern_ones) else $error("fault unit not ones");

   property p_far_end_fault_pattern_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (far_end_fault_pattern_active && s_q.far_end_fault_pattern_bit == 7'(PMF_FAR_END_FAULT_PATTERN_ONES))
         |-> !far_end_fault_pattern;
   endproperty
   a_far_end_fault_pattern_zero: assert property (p_far_end_fault_pattern_zero) else $error("unit end not zero");

   property p_far_end_fault_pattern_three;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(far_end_fault_pattern_active) |-> s_q.far_end_fault_pattern_units == PMF_FAR_END_FAULT_PATTERN_MIN_UNITS;
   endproperty
   a_far_end_fault_pattern_three: assert property (p_far_end_fault_pattern_three) else $error("too few fault units");

   property p_rx_block;
      @(posedge ref_clk) disable iff (!rst_n)
      (fiber && !sd_ok) |-> (rx_block && !link_up);
   endproperty
   a_rx_block: assert property (p_rx_block) else $error("fiber loss not blocked");

   property p_disable;
      @(posedge ref_clk) disable iff (!rst_n)
      s_q.dis_sy[1] |=> !mdio_oe;
   endproperty
   a_disable: assert property (p_disable) else $error("mdio driven while disabled");

   property p_fiber_rf;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(s_q.rfault) |-> !$past(fiber);
   endproperty
   a_fiber_rf: assert property (p_fiber_rf) else $error("fault taken in fiber");

   property p_forced;
      @(posedge ref_clk) disable iff (!rst_n)
      (!fiber && !s_q.r0[PMF_CTRL_ANEN]) |=>
         (speed_100 == $past(s_q.r0[PMF_CTRL_SPEED]));
   endproperty
   a_forced: assert property (p_forced) else $error("forced speed ignored");

   property p_nlp;
      @(posedge ref_clk) disable iff (!rst_n)
      link_pulse |-> (!$past(speed_100) && !$past(fiber));
   endproperty
   a_nlp: assert property (p_nlp) else $error("link pulse outside 10M");

endmodule : pmf_top
`default_nettype wire

/* File: core/pmf_pkg_unused_guard.sv */
// spare source file, holds no logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: tb/pmf_mdio_ctl.sv */
// management controller model clocking clause-22 frames over mdio
`timescale 1ns/100ps
`default_nettype none
module pmf_mdio_ctl (
   input wire logic ref_clk,
   input wire logic mdio_i,
   output logic mdc,
   output logic m_out,
   output logic m_oe
);
   initial begin
      mdc = 1'h0;
      m_out = 1'h1;
      m_oe = 1'h0;
   end
   // mdc idles low between frames, so no stray edges reach the port
   task automatic frame(input logic [1:0] op, input logic [4:0] a,
         input logic [4:0] i, input logic [15:0] v, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hFFFFFFFF, 2'h1, op, a, i, 2'h2, v};
      for (int b = 63; b >= 0; b--) begin
         m_oe <= !(op == 2'h2 && b < 18);
         m_out <= f[b];
         mdc <= 1'h0;
         repeat (7) @(posedge ref_clk);
         @(negedge ref_clk);
         rd = {rd[14:0], mdio_i};
         @(posedge ref_clk);
         mdc <= 1'h1;
         repeat (8) @(posedge ref_clk);
      end
      mdc <= 1'h0;
      m_oe <= 1'h0;
   endtask : frame
endmodule : pmf_mdio_ctl
`default_nettype wire

/* File: tb/test_pmf_top.sv */
// self-checking bench: apb and mdio access, faults, interrupt
`timescale 1ns/100ps
`default_nettype none
module test_pmf_top;
   import pmf_pkg::*;
   logic ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, mgmt_port_disable = 1'h0, fiber_signal_detect = 1'h0;
   logic rx_pll_lock = 1'h1, link_ok = 1'h0, tx_active = 1'h0;
   logic an_done = 1'h0, partner_page_valid = 1'h0, pd_link_pulse = 1'h0;
   logic pd_idle_symbols = 1'h0, e, pready, pslverr, mdc, mdio_i, mdio_o;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic [15:0] partner_page = 16'h2000, adv_page, r;
   logic [4:0] phy_addr_pin = 5'h05;
   logic [2:0] led_strap_pin_i = 3'h0, led_strap_pin_o;
   logic mdio_oe, m_out, m_oe, led_strap_pin_oe, speed_100, full_duplex;
   logic link_up, rx_block, link_pulse, far_end_fault_pattern_active, far_end_fault_pattern;
   logic mii_high_drive, mgmt_irq_n_o, mgmt_irq_oe;
   int err_total = 0, samples_checked = 0, k, n;
   // released line floats high through its pull-up
   assign mdio_i = mdio_oe ? mdio_o : (m_oe ? m_out : 1'h1);
   always #2.5 ref_clk = ~ref_clk;
   pmf_top #(.NLP_CYCLES(20)) i_pmf_top (.*);
   pmf_mdio_ctl i_pmf_mdio_ctl (.*);
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic step(inout int c);
      @(negedge ref_clk);
      c++;
      if (c > 4000) begin
         err_total++;
         print_verdict();
      end
   endtask : step
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] v);
      n = 0;
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge ref_clk);
      penable <= 1'h1;
      // answer, read data and error are all taken at the ready edge
      do begin
         @(posedge ref_clk);
         n++;
         if (n > 4000) begin
            err_total++;
            print_verdict();
         end
      end while (pready !== 1'h1);
      d = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(negedge ref_clk);
   endtask : apb
   task automatic rd_chk(input logic [4:0] i, input logic [31:0] x);
      apb(1'h0, {1'h0, i, 2'h0}, 32'h0);
      check(d, x);
   endtask : rd_chk
   task automatic wr(input logic [4:0] i, input logic [31:0] v);
      apb(1'h1, {1'h0, i, 2'h0}, v);
   endtask : wr
   task automatic mf(input logic [1:0] o, input logic [4:0] a,
         input logic [4:0] i, input logic [15:0] v);
      @(posedge ref_clk);
      i_pmf_mdio_ctl.frame(o, a, i, v, r);
   endtask : mf
   task automatic rst(input logic [2:0] s);
      @(posedge ref_clk);
      rst_n <= 1'h0;
      led_strap_pin_i <= s;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'h1;
      repeat (10) @(posedge ref_clk);
   endtask : rst
   // ********
   // scenarios
   // ********
   initial begin
      rst(3'h0);
      rd_chk(PMF_IDX_CTRL, 32'h0);
      check({speed_100, full_duplex, led_strap_pin_oe}, 3'h1);
      rd_chk(PMF_IDX_STAT, 32'h7809);
      rd_chk(PMF_IDX_CFG, 32'h0);
      apb(1'h0, 8'h80, 32'h0);
      check({e, d}, 33'h100000000);
      k = 0;
      while (link_pulse !== 1'h1) step(k);
      k = 0;
      do step(k); while (link_pulse !== 1'h1);
      check(k, 20);
      wr(PMF_IDX_DRV, 32'h0800);
      check(mii_high_drive, 1'h1);
      $display("straps, registers, pulses done");
      mf(PMF_OP_WRITE, 5'h05, PMF_IDX_DRV, 16'h0000);
      check(mii_high_drive, 1'h0);
      mf(PMF_OP_WRITE, 5'h05, PMF_IDX_IEN, 16'h0010);
      mf(PMF_OP_WRITE, 5'h06, PMF_IDX_IEN, 16'h00F0);
      mf(PMF_OP_READ, 5'h05, PMF_IDX_IEN, 16'h0);
      check(r, 16'h0010);
      mf(PMF_OP_READ, 5'h04, PMF_IDX_IEN, 16'h0);
      check(r, 16'hFFFF);
      mgmt_port_disable <= 1'h1;
      mf(PMF_OP_WRITE, 5'h05, PMF_IDX_IEN, 16'h0000);
      mf(PMF_OP_READ, 5'h05, PMF_IDX_IEN, 16'h0);
      check(r, 16'hFFFF);
      rd_chk(PMF_IDX_IEN, 32'h0010);
      $display("management port done");
      @(posedge ref_clk);
      mgmt_port_disable <= 1'h0;
      wr(PMF_IDX_IEN, 32'h0012);
      apb(1'h0, {1'h0, PMF_IDX_IST, 2'h0}, 32'h0);
      check({mgmt_irq_oe, mgmt_irq_n_o}, 2'h3);
      @(posedge ref_clk);
      link_ok <= 1'h1;
      repeat (4) @(negedge ref_clk);
      check(mgmt_irq_n_o, 1'h0);
      rd_chk(PMF_IDX_IST, 32'h0014);
      check(mgmt_irq_n_o, 1'h1);
      wr(PMF_IDX_IEN, 32'h0);
      check(mgmt_irq_oe, 1'h0);
      $display("interrupt done");
      wr(PMF_IDX_CTRL, 32'h1000);
      @(posedge ref_clk);
      partner_page_valid <= 1'h1;
      @(posedge ref_clk);
      partner_page_valid <= 1'h0;
      rd_chk(PMF_IDX_LPA, 32'h2000);
      rd_chk(PMF_IDX_STAT, 32'h781D);
      wr(PMF_IDX_ADV, 32'h21E1);
      check(adv_page, 16'h21E1);
      wr(PMF_IDX_CFG, 32'h0005);
      rd_chk(PMF_IDX_CFG, 32'h0005);
      check(adv_page, 16'h01E1);
      repeat (6) @(negedge ref_clk);
      check({rx_block, link_up, far_end_fault_pattern_active}, 3'h5);
      k = 0;
      while (far_end_fault_pattern !== 1'h0) step(k);
      for (int u = 0; u < 3; u++) begin
         n = 0;
         step(k);
         while (far_end_fault_pattern === 1'h1) begin
            n++;
            step(k);
         end
         check(n, 84);
      end
      wr(PMF_IDX_CTRL, 32'h5000);
      repeat (300) @(negedge ref_clk);
      check(far_end_fault_pattern_active, 1'h0);
      $display("faults done");
      @(posedge ref_clk);
      pd_idle_symbols <= 1'h1;
      rst(3'h1);
      repeat (40) @(negedge ref_clk);
      check(speed_100, 1'h1);
      $display("parallel detect done");
      print_verdict();
   end
endmodule : test_pmf_top
`default_nettype wire
